// ### inc/jtpg_defines.svh
// Summary of operation
// [RL1] programmer uses only the four test pins
// [RL2] port usable with fuse set, disable clear
// [RL3] reset low clears disable after two clocks
// [RL4] reset reclaim unsuitable for scan or debug
// [RL5] test clock below chip maximum frequency
// [RL6] all shift registers move lsb first
// [RL7] four-bit instruction register selects data path
// [RL8] run-test/idle generates internal programming clocks
// [RL9] opcode 0xC selects one-bit reset chain
// [RL10] reset chain one holds part in reset
// [RL11] reset time-out follows chain release
// [RL12] programmer resets part before programming
// [RL13] opcode 0x4 unlock register compared at update
// [RL14] opcode 0x5 command register captures prior result
// [RL15] command shifts, updates, executes in idle
// [RL16] opcode 0x6 byte register is command low byte
// [RL17] page-load byte written within eleven clocks
// [RL18] page-load alternates low then high byte
// [RL19] page-load address pre-increments except first
// [RL20] opcode 0x7 captures selected memory byte
// [RL21] page-read alternates low then high byte
// [RL22] page-read address post-increments after high byte
// [RL23] unlock needs exact sixteen-bit signature match
// [RL24] unlock register clears on power-on reset
// [RL25] standard sixteen-state tap controller
`ifndef JTPG_DEFINES_SVH
`define JTPG_DEFINES_SVH
`define JTPG_IR_WIDTH 4
`define JTPG_OP_CHIP_RESET 4'hC
`define JTPG_OP_UNLOCK 4'h4
`define JTPG_OP_COMMAND 4'h5
`define JTPG_OP_PAGE_LOAD 4'h6
`define JTPG_OP_PAGE_READ 4'h7
`define JTPG_OP_BYPASS 4'hF
`define JTPG_UNLOCK_WIDTH 16
`define JTPG_CMD_WIDTH 15
`define JTPG_BYTE_WIDTH 8
`define JTPG_SIGNATURE 16'hA370
`define JTPG_LOAD_DELAY 4'h6
`define JTPG_DISABLE_CLEAR_CYCLES 2'h2
`endif

// ### inc/jtpg_pkg.sv
package jtpg_pkg;
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } jtpg_tap_type;
endpackage : jtpg_pkg

// ### core/jtpg_sync.sv
`timescale 1ns/1ps
// two-flop level synchroniser
module jtpg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : jtpg_sync

// ### core/jtpg_port.sv
`timescale 1ns/1ps
`include "jtpg_defines.svh"
module jtpg_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic test_port_enable_fuse,
  input wire logic test_port_disable_set,
  input wire logic ext_reset_n,
  output logic test_port_disable_bit,
  output logic part_reset,
  output logic program_mode,
  output logic tap_in_reset,
  output logic [`JTPG_CMD_WIDTH-1:0] mem_command,
  output logic mem_command_strobe,
  output logic mem_exec_strobe,
  input wire logic [`JTPG_CMD_WIDTH-1:0] mem_result,
  output logic [`JTPG_BYTE_WIDTH-1:0] page_byte,
  output logic page_byte_high,
  output logic page_write_strobe,
  output logic addr_increment,
  input wire logic [`JTPG_BYTE_WIDTH-1:0] read_low_byte,
  input wire logic [`JTPG_BYTE_WIDTH-1:0] read_high_byte
);
  import jtpg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // chip-clock side: port disable bit and its reclaim
  logic [2:0] sync_pins;
  logic disable_bit, next_disable_bit;
  logic [1:0] low_cnt, next_low_cnt;
  logic port_live, next_port_live;
  logic port_live_tck;

  jtpg_sync #(.WIDTH(3)) u_sync_chip (
    .clk(clk),
    .rst(rst),
    .async_in({test_port_enable_fuse, ext_reset_n, test_port_disable_set}),
    .sync_out(sync_pins)
  );

  always_comb begin
    next_disable_bit = disable_bit;
    next_low_cnt = 2'h0;
    // [RL3] reset low reclaims
    if (disable_bit && !sync_pins[1]) begin
      next_low_cnt = low_cnt + 2'h1;
      if (low_cnt + 2'h1 >= `JTPG_DISABLE_CLEAR_CYCLES) begin
        next_disable_bit = 1'b0;
        next_low_cnt = 2'h0;
      end
    end
    if (sync_pins[0]) begin
      next_disable_bit = 1'b1;
    end
    // [RL2] fuse and disable gate port
    next_port_live = sync_pins[2] && !disable_bit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disable_bit <= 1'b0;
      low_cnt <= 2'h0;
      port_live <= 1'b0;
    end else begin
      disable_bit <= next_disable_bit;
      low_cnt <= next_low_cnt;
      port_live <= next_port_live;
    end
  end

  assign test_port_disable_bit = disable_bit;

  jtpg_sync #(.WIDTH(1)) u_sync_live (
    .clk(tck),
    .rst(rst),
    .async_in(port_live),
    .sync_out(port_live_tck)
  );

  ////////////////////////////////////////////////////////////////////////////
  // tck side: tap controller
  jtpg_tap_type tap;
  jtpg_tap_type next_tap;

  // [RL25] standard tap state walk
  always_comb begin
    case (tap)
      TAP_RESET: next_tap = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_tap = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_tap = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_tap = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_tap = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tap = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_tap = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_tap = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_tap = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_tap = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
      default: next_tap = TAP_RESET;
    endcase
    if (!port_live_tck) begin
      next_tap = TAP_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction and data registers
  logic [`JTPG_IR_WIDTH-1:0] ir_shift, next_ir_shift;
  logic [`JTPG_IR_WIDTH-1:0] ir, next_ir;
  logic reset_chain, next_reset_chain;
  logic [`JTPG_UNLOCK_WIDTH-1:0] unlock, next_unlock;
  logic unlocked, next_unlocked;
  logic [`JTPG_CMD_WIDTH-1:0] cmd_shift, next_cmd_shift;
  logic [`JTPG_CMD_WIDTH-1:0] cmd, next_cmd;
  logic cmd_stb, next_cmd_stb;
  logic exec_stb, next_exec_stb;
  logic bypass, next_bypass;
  logic load_high, next_load_high;
  logic load_first, next_load_first;
  logic read_high, next_read_high;
  logic [`JTPG_BYTE_WIDTH-1:0] hold, next_hold;
  logic hold_high, next_hold_high;
  logic [3:0] load_cnt, next_load_cnt;
  logic load_busy, next_load_busy;
  logic wr_stb, next_wr_stb;
  logic inc_stb, next_inc_stb;
  logic tdo_q, next_tdo_q;
  logic tdo_en, next_tdo_en;
  logic sel_reset, sel_unlock, sel_cmd, sel_load, sel_read;

  // [RL7] instruction selects data path
  always_comb begin
    sel_reset = (ir == `JTPG_OP_CHIP_RESET);
    sel_unlock = (ir == `JTPG_OP_UNLOCK);
    sel_cmd = (ir == `JTPG_OP_COMMAND) && unlocked;
    sel_load = (ir == `JTPG_OP_PAGE_LOAD) && unlocked;
    sel_read = (ir == `JTPG_OP_PAGE_READ) && unlocked;
  end

  always_comb begin
    next_ir_shift = ir_shift;
    next_ir = ir;
    next_reset_chain = reset_chain;
    next_unlock = unlock;
    next_unlocked = unlocked;
    next_cmd_shift = cmd_shift;
    next_cmd = cmd;
    next_cmd_stb = 1'b0;
    next_exec_stb = 1'b0;
    next_bypass = bypass;
    next_load_high = load_high;
    next_load_first = load_first;
    next_read_high = read_high;
    next_hold = hold;
    next_hold_high = hold_high;
    next_load_cnt = load_cnt;
    next_load_busy = load_busy;
    next_wr_stb = 1'b0;
    next_inc_stb = 1'b0;
    if (load_busy) begin
      next_load_cnt = load_cnt - 4'h1;
      if (load_cnt == 4'h1) begin
        next_load_busy = 1'b0;
        next_wr_stb = 1'b1;
      end
    end
    case (tap)
      TAP_RESET: begin
        // [RL9] tap reset restores bypass
        next_ir = `JTPG_OP_BYPASS;
      end
      TAP_CAP_IR: next_ir_shift = 4'h1;
      // [RL6] lsb-first shifting
      TAP_SHIFT_IR: next_ir_shift = {tdi, ir_shift[3:1]};
      TAP_UPD_IR: begin
        next_ir = ir_shift;
        next_load_high = 1'b0;
        next_load_first = 1'b1;
        next_read_high = 1'b0;
      end
      TAP_CAP_DR: begin
        // [RL14] capture previous result
        if (sel_cmd) begin
          next_cmd_shift = mem_result;
        end
        // [RL20] capture selected byte
        if (sel_read) begin
          // [RL21] low then high
          next_cmd_shift[7:0] = read_high ? read_high_byte : read_low_byte;
          next_read_high = !read_high;
          // [RL22] post-increment after high
          next_inc_stb = read_high;
        end
        next_bypass = 1'b0;
      end
      TAP_SHIFT_DR: begin
        // [RL10] chain bit shifts through
        if (sel_reset) begin
          next_reset_chain = tdi;
        end else if (sel_unlock) begin
          next_unlock = {tdi, unlock[15:1]};
        end else if (sel_cmd) begin
          // [RL15] shift result out, command in
          next_cmd_shift = {tdi, cmd_shift[14:1]};
        end else if (sel_load || sel_read) begin
          // [RL16] byte is command low bits
          next_cmd_shift[7:0] = {tdi, cmd_shift[7:1]};
        end else begin
          next_bypass = tdi;
        end
      end
      TAP_UPD_DR: begin
        // [RL13] compare at update
        if (sel_unlock) begin
          // [RL23] exact signature match
          next_unlocked = (unlock == `JTPG_SIGNATURE);
        end
        if (sel_cmd) begin
          next_cmd = cmd_shift;
          next_cmd_stb = 1'b1;
        end
        // [RL17] copy to holding register
        if (sel_load) begin
          next_hold = cmd_shift[7:0];
          // [RL18] alternate low then high
          next_hold_high = load_high;
          next_load_high = !load_high;
          next_load_first = 1'b0;
          // [RL19] pre-increment except first
          next_inc_stb = !load_high && !load_first;
          next_load_busy = 1'b1;
          next_load_cnt = `JTPG_LOAD_DELAY;
        end
      end
      TAP_IDLE: begin
        // [RL8] idle generates programming clock
        next_exec_stb = sel_cmd;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    next_tdo_en = (tap == TAP_SHIFT_DR) || (tap == TAP_SHIFT_IR);
    if (tap == TAP_SHIFT_IR) begin
      next_tdo_q = ir_shift[0];
    end else if (sel_reset) begin
      next_tdo_q = reset_chain;
    end else if (sel_unlock) begin
      next_tdo_q = unlock[0];
    end else if (sel_cmd || sel_load || sel_read) begin
      next_tdo_q = cmd_shift[0];
    end else begin
      next_tdo_q = bypass;
    end
  end

  // [RL24] unlock clears on power-on reset
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      tap <= TAP_RESET;
      ir_shift <= 4'h0;
      ir <= `JTPG_OP_BYPASS;
      reset_chain <= 1'b0;
      unlock <= 16'h0000;
      unlocked <= 1'b0;
      cmd_shift <= 15'h0000;
      cmd <= 15'h0000;
      cmd_stb <= 1'b0;
      exec_stb <= 1'b0;
      bypass <= 1'b0;
      load_high <= 1'b0;
      load_first <= 1'b1;
      read_high <= 1'b0;
      hold <= 8'h00;
      hold_high <= 1'b0;
      load_cnt <= 4'h0;
      load_busy <= 1'b0;
      wr_stb <= 1'b0;
      inc_stb <= 1'b0;
    end else begin
      tap <= next_tap;
      ir_shift <= next_ir_shift;
      ir <= next_ir;
      reset_chain <= next_reset_chain;
      unlock <= next_unlock;
      unlocked <= next_unlocked;
      cmd_shift <= next_cmd_shift;
      cmd <= next_cmd;
      cmd_stb <= next_cmd_stb;
      exec_stb <= next_exec_stb;
      bypass <= next_bypass;
      load_high <= next_load_high;
      load_first <= next_load_first;
      read_high <= next_read_high;
      hold <= next_hold;
      hold_high <= next_hold_high;
      load_cnt <= next_load_cnt;
      load_busy <= next_load_busy;
      wr_stb <= next_wr_stb;
      inc_stb <= next_inc_stb;
    end
  end

  // tdo changes on the falling test clock edge
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      tdo_q <= 1'b0;
      tdo_en <= 1'b0;
    end else begin
      tdo_q <= next_tdo_q;
      tdo_en <= next_tdo_en;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_en;
  // [RL10] unlatched chain drives reset
  assign part_reset = reset_chain;
  // [RL11] time-out lives in the chip reset logic
  assign program_mode = unlocked;
  assign tap_in_reset = (tap == TAP_RESET);
  assign mem_command = cmd;
  assign mem_command_strobe = cmd_stb;
  assign mem_exec_strobe = exec_stb;
  assign page_byte = hold;
  assign page_byte_high = hold_high;
  assign page_write_strobe = wr_stb;
  assign addr_increment = inc_stb;
endmodule : jtpg_port

// ### tb/jtpg_port_monitor.sv
`timescale 1ns/1ps
`include "jtpg_defines.svh"
module jtpg_port_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdo_oe,
  input wire logic test_port_enable_fuse,
  input wire logic test_port_disable_set,
  input wire logic ext_reset_n,
  input wire logic test_port_disable_bit,
  input wire logic part_reset,
  input wire logic program_mode,
  input wire logic tap_in_reset,
  input wire logic [`JTPG_CMD_WIDTH-1:0] mem_command,
  input wire logic mem_command_strobe,
  input wire logic [`JTPG_BYTE_WIDTH-1:0] page_byte,
  input wire logic page_write_strobe,
  input wire logic addr_increment
);
  logic [4:0] dead_cnt;
  logic [4:0] next_dead_cnt;
  // tck edges since the port went dead
  always_comb begin
    next_dead_cnt = dead_cnt;
    if (test_port_enable_fuse && !test_port_disable_bit) begin
      next_dead_cnt = 5'h00;
    end else if (dead_cnt != 5'h1F) begin
      next_dead_cnt = dead_cnt + 5'h01;
    end
  end
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      dead_cnt <= 5'h00;
    end else begin
      dead_cnt <= next_dead_cnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_TAP_RESET: assert property (@(posedge tck) disable iff (rst)
    tms [*6] |=> tap_in_reset) else $error("tap not in reset");
  AST_OE_IDLE: assert property (@(posedge tck) disable iff (rst)
    tap_in_reset |-> !tdo_oe) else $error("tdo driven in reset");
  AST_PORT_DEAD: assert property (@(posedge tck) disable iff (rst)
    dead_cnt >= 5'h18 |-> tap_in_reset) else $error("dead port active");
  AST_DIS_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (test_port_disable_bit && !ext_reset_n && !test_port_disable_set) [*4]
    |=> !test_port_disable_bit) else $error("disable bit not cleared");
  AST_DIS_SET: assert property (@(posedge clk) disable iff (rst)
    test_port_disable_set [*4] |-> test_port_disable_bit)
    else $error("disable bit not set");
  AST_CMD_PULSE: assert property (@(posedge tck) disable iff (rst)
    mem_command_strobe |=> !mem_command_strobe) else $error("long strobe");
  AST_CMD_APPLY: assert property (@(posedge tck) disable iff (rst)
    $changed(mem_command) |-> ##[0:1] mem_command_strobe)
    else $error("command change without strobe");
  AST_WR_WINDOW: assert property (@(posedge tck) disable iff (rst)
    $changed(page_byte) |-> ##[1:10] page_write_strobe)
    else $error("page write late");
  AST_INC_PULSE: assert property (@(posedge tck) disable iff (rst)
    addr_increment |=> !addr_increment) else $error("long increment");
  COV_UNLOCK: cover property (@(posedge tck) $rose(program_mode));
  COV_WRITE: cover property (@(posedge tck) page_write_strobe);
  COV_CHAIN: cover property (@(posedge tck) $rose(part_reset));
endmodule : jtpg_port_monitor

bind jtpg_port jtpg_port_monitor mon (.clk, .rst, .tck, .tms, .tdo_oe,
  .test_port_enable_fuse, .test_port_disable_set, .ext_reset_n,
  .test_port_disable_bit, .part_reset, .program_mode, .tap_in_reset,
  .mem_command, .mem_command_strobe, .page_byte, .page_write_strobe,
  .addr_increment);

// ### tb/jtpg_prog.sv
`timescale 1ns/1ps
module jtpg_prog #(
  parameter int IDLE = 12
) (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  logic q;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    #3;
    q = tdo;
    tck = 1'b1;
    #3;
    tck = 1'b0;
  endtask : tick
  task automatic go_reset;
    repeat (6) tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
  endtask : go_reset
  task automatic frame(input logic ir, input int n, input logic [15:0] din,
    output logic [15:0] dout);
    dout = '0;
    tick(1'b1, ~tdi);
    if (ir) begin
      tick(1'b1, ~tdi);
    end
    tick(1'b0, ~tdi);
    tick(1'b0, ~tdi);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = q;
    end
    tick(1'b1, ~tdi);
    repeat (IDLE + 1) tick(1'b0, ~tdi);
  endtask : frame
endmodule : jtpg_prog

// ### tb/tb_jtpg_port.sv
`timescale 1ns/1ps
`include "jtpg_defines.svh"
module tb_jtpg_port;
  localparam int IDLE = 12;
  logic clk, rst, tck, tms, tdi, tdo, tdo_oe;
  logic test_port_enable_fuse, test_port_disable_set, ext_reset_n;
  logic test_port_disable_bit, part_reset, program_mode, tap_in_reset;
  logic mem_command_strobe, mem_exec_strobe, page_byte_high;
  logic page_write_strobe, addr_increment;
  logic [`JTPG_CMD_WIDTH-1:0] mem_command, mem_result;
  logic [`JTPG_BYTE_WIDTH-1:0] page_byte, read_low_byte, read_high_byte;
  logic [15:0] dout, r;
  logic [31:0] seed;
  logic [8:0] wq[$];
  logic [8:0] mq[$];
  int mismatches, tests_run, n_inc, n_exec, n_oe, i;
  jtpg_port dut (.clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .test_port_enable_fuse, .test_port_disable_set, .ext_reset_n,
    .test_port_disable_bit, .part_reset, .program_mode, .tap_in_reset,
    .mem_command, .mem_command_strobe, .mem_exec_strobe, .mem_result,
    .page_byte, .page_byte_high, .page_write_strobe, .addr_increment,
    .read_low_byte, .read_high_byte);
  jtpg_prog #(.IDLE(IDLE)) prog (.tck, .tms, .tdi, .tdo);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge tck) begin
    if (addr_increment === 1'b1) n_inc++;
    if (mem_exec_strobe === 1'b1) n_exec++;
    if (tdo_oe === 1'b1) n_oe++;
    if (page_write_strobe === 1'b1) wq.push_back({page_byte_high, page_byte});
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic instr(input logic [3:0] op);
    prog.frame(1'b1, 4, {12'h000, op}, dout);
  endtask : instr
  task automatic data(input int n, input logic [15:0] v);
    prog.frame(1'b0, n, v, dout);
  endtask : data
  task results;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    #300000;
    mismatches++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hB0DA3820;
    rst = 1'b1;
    test_port_enable_fuse = 1'b0;
    test_port_disable_set = 1'b0;
    ext_reset_n = 1'b1;
    mem_result = '0;
    read_low_byte = '0;
    read_high_byte = '0;
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    check("por_mode", program_mode, 0);
    check("por_tap", tap_in_reset, 1);
    prog.go_reset;
    instr(`JTPG_OP_UNLOCK);
    data(16, `JTPG_SIGNATURE);
    check("fuse_off", program_mode, 0);
    @(negedge clk) test_port_enable_fuse = 1'b1;
    test_port_disable_set = 1'b1;
    repeat (4) @(negedge clk);
    test_port_disable_set = 1'b0;
    repeat (3) @(negedge clk);
    check("dis_set", test_port_disable_bit, 1);
    prog.go_reset;
    instr(`JTPG_OP_UNLOCK);
    data(16, `JTPG_SIGNATURE);
    check("dis_on", program_mode, 0);
    @(negedge clk) ext_reset_n = 1'b0;
    repeat (3) @(negedge clk);
    check("dis_wait", test_port_disable_bit, 1);
    @(negedge clk);
    check("dis_clr", test_port_disable_bit, 0);
    repeat (2) @(negedge clk);
    ext_reset_n = 1'b1;
    repeat (4) @(negedge clk);
    prog.go_reset;
    instr(`JTPG_OP_CHIP_RESET);
    data(1, 16'h0001);
    check("chain_on", part_reset, 1);
    check("tap_kept", tap_in_reset, 0);
    data(1, 16'h0000);
    check("chain_off", part_reset, 0);
    instr(`JTPG_OP_UNLOCK);
    r = 16'($random(seed));
    data(16, `JTPG_SIGNATURE ^ (r | 16'h0001));
    check("bad_sig", program_mode, 0);
    n_oe = 0;
    data(16, `JTPG_SIGNATURE);
    check("good_sig", program_mode, 1);
    check("oe_shift", 16'(n_oe), 16'h0010);
    check("oe_idle", tdo_oe, 0);
    n_exec = 0;
    instr(`JTPG_OP_COMMAND);
    for (i = 0; i < 3; i++) begin
      @(negedge clk) mem_result = 15'($random(seed));
      r = 16'($random(seed));
      data(15, r);
      check("cmd", mem_command, r[14:0]);
      check("result", dout[14:0], mem_result);
    end
    instr(`JTPG_OP_PAGE_LOAD);
    check("exec", 16'(n_exec), 16'(4 * IDLE + 4));
    n_inc = 0;
    wq.delete();
    for (i = 0; i < 3; i++) begin
      r = 16'($random(seed));
      mq.push_back({i[0], r[7:0]});
      data(8, r);
    end
    check("inc_load", 16'(n_inc), 16'h0001);
    check("writes", 16'(wq.size()), 16'h0003);
    foreach (mq[k]) check("byte", wq[k], mq[k]);
    instr(`JTPG_OP_PAGE_READ);
    n_inc = 0;
    for (i = 0; i < 4; i++) begin
      @(negedge clk) read_low_byte = 8'($random(seed));
      read_high_byte = 8'($random(seed));
      data(8, 16'($random(seed)));
      check("rd", dout[7:0], i[0] ? read_high_byte : read_low_byte);
    end
    check("inc_read", 16'(n_inc), 16'h0002);
    instr(`JTPG_OP_UNLOCK);
    data(16, 16'h0000);
    check("exit", program_mode, 0);
    data(16, `JTPG_SIGNATURE);
    check("relock", program_mode, 1);
    @(negedge clk) rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check("por_again", program_mode, 0);
    check("tap_again", tap_in_reset, 1);
    results;
  end
endmodule : tb_jtpg_port
